// ===== pkg/touch_ctrl_map.vh
/*
  Register map, field positions, codes and timing figures of the touch
  screen controller. Included by the controller source; definitions only.
*/
`ifndef TOUCH_CTRL_MAP_VH
`define TOUCH_CTRL_MAP_VH

// Word indexes on the bus (byte address = index * 4)
`define IDX_CTRL 6'h00
`define IDX_CHAN_MASK 6'h01
`define IDX_COMMAND 6'h02
`define IDX_STATUS 6'h03
`define IDX_CHAN_DATA 6'h04

// Control register fields
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_FIVE_WIRE 2
`define CTRL_PULLUP_LO 3
`define CTRL_PULLUP_HI 4
`define CTRL_SETTLE_LO 5
`define CTRL_SETTLE_HI 7
`define CTRL_AUX_TRIG_EN 8
`define CTRL_AUX_EDGE 9
`define CTRL_WIDTH 10
`define CTRL_RESET 10'h000

// Channel mask, one bit per channel; command bit
`define CHAN_COUNT 5
`define CHAN_MASK_RESET 5'h1f
`define CMD_START_BIT 0

// Status register fields
`define STAT_TOUCH 0
`define STAT_DATA_AVAIL 1
`define STAT_BUSY 2
`define STAT_START_PEND 3
`define STAT_STATE_LO 4
`define STAT_STATE_HI 6

// Operating modes
`define MODE_MANUAL 2'h0
`define MODE_PEN_INT 2'h1
`define MODE_PEN_TRIG 2'h2

// Channel indexes, in read-out order
`define CH_X 3'h0
`define CH_Y 3'h1
`define CH_Z1 3'h2
`define CH_Z2 3'h3
`define CH_AUX 3'h4
`define CH_END 3'h5

// Panel bias setups
`define BIAS_OFF 3'h0
`define BIAS_PEN 3'h1
`define BIAS_X 3'h2
`define BIAS_Y 3'h3
`define BIAS_Z1 3'h4
`define BIAS_Z2 3'h5
`define BIAS_AUX 3'h6

// ADC input selection
`define ADC_IN_XPLUS 2'h0
`define ADC_IN_YSHEET 2'h1
`define ADC_IN_AUX 2'h2

// Channel data word
`define CHAN_EMPTY_WORD 16'h8000
`define SPI_READCHAN 3'h1

// Timing: one settle delay step, clock rate
`define SETTLE_UNIT_NS 1000
`define CLK_MHZ 200

// Pin synchroniser slots and their reset levels
`define PIN_SCLK 0
`define PIN_CSN 1
`define PIN_MOSI 2
`define PIN_PEN 3
`define PIN_AUX 4
`define PIN_HWRST 5
`define PIN_COUNT 6
`define PIN_RESET 6'h22

`endif

// ===== src/touch_ctrl.v
/*
  Control logic of a resistive touch screen controller: pen detection,
  panel bias sequencing for X, Y, Z1, Z2 and AUX, a channel result queue,
  a Wishbone classic register slave and a CPOL=0/CPHA=0 serial read-out port.
  Assumes an ADC in the ref_clk domain that pulses adcDone with adcData
  after adcStart; the pen comparator, aux pin, serial pins and hardware
  reset pin are asynchronous and are synchronised here.

  // Function
  // R1 - Interrupt is active-low open drain, else released
  // R2 - Interrupt on pen touch or data available
  // R3 - Low hardware reset pin resets control logic
  // R4 - Pen-interrupt mode interrupts, pen-trigger mode acquires
  // R5 - Every pen detection sets touch-detected flag
  // R6 - Pen-interrupt mode: detection pulls interrupt low
  // R7 - Status read clears flag, releases interrupt
  // R8 - Pen detect settles quarter of delay setting
  // R9 - Four selectable pen pull-up resistances
  // R10 - Pen bias X-plus to Y-minus, watch X-plus
  // R11 - Four-wire aux pin is 12-bit ADC input
  // R12 - Aux edge or level can trigger acquisition
  // R13 - Five-wire panel senses all coordinates on wiper
  // R14 - Y: bias Y sheet, convert X-plus
  // R15 - X: bias X sheet, convert through Y sheet
  // R16 - Results are divider ratio, zero to 4095
  // R17 - Four-wire panel adds Z1, Z2 pressure setups
  // R18 - Five-wire panel gives no pressure channels
  // R19 - Results unsigned 12-bit, held until read
  // R20 - Serial port CPOL 0, CPHA 0
  // R21 - Commands arriving while busy are discarded
  // R22 - Queue order X, Y, Z1, Z2, AUX; once
*/
`timescale 1ns/1ps
`include "touch_ctrl_map.vh"

module touch_ctrl (
  input wire ref_clk,
  input wire resetn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire hwResetNIn,
  input wire penDetectIn,
  input wire auxPinIn,
  input wire spiSclkIn,
  input wire spiCsNIn,
  input wire spiMosiIn,
  output reg spiMisoOut,
  output reg spiMisoOe,
  output reg hostInterruptNOut,
  output reg hostInterruptNOe,
  output reg [2:0] biasSel,
  output reg [1:0] adcInSel,
  output reg [1:0] penPullupSel,
  output reg adcStart,
  input wire adcDone,
  input wire [11:0] adcData
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_PEN_BIAS = 3'h1;
  localparam [2:0] ST_PEN_EVAL = 3'h2;
  localparam [2:0] ST_CH_SEL = 3'h3;
  localparam [2:0] ST_SETTLE = 3'h4;
  localparam [2:0] ST_CONV = 3'h5;
  localparam [2:0] ST_HOLD = 3'h6;

  localparam integer SETTLE_UNIT_CYC = `SETTLE_UNIT_NS * `CLK_MHZ / 1000;
  localparam [`PIN_COUNT-1:0] PIN_RST_VAL = `PIN_RESET;

  // Pin synchronisers: a change counts once stages two and three agree
  reg [`PIN_COUNT-1:0] pinS1;
  reg [`PIN_COUNT-1:0] pinS2;
  reg [`PIN_COUNT-1:0] pinS3;
  reg [`PIN_COUNT-1:0] pinLvl;
  reg [`PIN_COUNT-1:0] pinLvlD;
  wire [`PIN_COUNT-1:0] pinRaw;
  assign pinRaw = {hwResetNIn, auxPinIn, penDetectIn, spiMosiIn, spiCsNIn, spiSclkIn};

  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : gSync
      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          pinS1[gi] <= PIN_RST_VAL[gi];
          pinS2[gi] <= PIN_RST_VAL[gi];
          pinS3[gi] <= PIN_RST_VAL[gi];
          pinLvl[gi] <= PIN_RST_VAL[gi];
          pinLvlD[gi] <= PIN_RST_VAL[gi];
        end else begin
          pinS1[gi] <= pinRaw[gi];
          pinS2[gi] <= pinS1[gi];
          pinS3[gi] <= pinS2[gi];
          if (pinS2[gi] == pinS3[gi]) begin
            pinLvl[gi] <= pinS3[gi];
          end
          pinLvlD[gi] <= pinLvl[gi];
        end
      end
    end
  endgenerate

  wire ctlRst = ~pinLvl[`PIN_HWRST]; // [R3]
  wire sclkRise = pinLvl[`PIN_SCLK] & ~pinLvlD[`PIN_SCLK];
  wire sclkFall = ~pinLvl[`PIN_SCLK] & pinLvlD[`PIN_SCLK];
  wire csActive = ~pinLvl[`PIN_CSN];
  wire auxRise = pinLvl[`PIN_AUX] & ~pinLvlD[`PIN_AUX];

  reg [`CTRL_WIDTH-1:0] ctrlReg;
  reg [`CHAN_COUNT-1:0] chanMaskReg;
  reg touchFlagReg;
  reg startPendReg;
  reg [2:0] stateReg;
  reg [2:0] chanIdxReg;
  reg [15:0] waitCntReg;
  reg [11:0] chanData [0:`CHAN_COUNT-1];
  reg [`CHAN_COUNT-1:0] chanValidReg;
  reg [3:0] spiBitCntReg;
  reg [6:0] spiCmdReg;
  reg [15:0] spiOutReg;
  reg spiReadingReg;

  wire [1:0] mode = ctrlReg[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire fiveWire = ctrlReg[`CTRL_FIVE_WIRE];
  wire auxTrigEn = ctrlReg[`CTRL_AUX_TRIG_EN];
  wire busy = (stateReg == ST_CH_SEL) | (stateReg == ST_SETTLE) | (stateReg == ST_CONV);
  wire penMode = (mode == `MODE_PEN_INT) | (mode == `MODE_PEN_TRIG);

  // Settle delay: (setting + 1) steps; pen detection waits a quarter of it
  wire [31:0] settleProd = ({29'h0, ctrlReg[`CTRL_SETTLE_HI:`CTRL_SETTLE_LO]} + 32'h1) *
                           SETTLE_UNIT_CYC;
  wire [15:0] settleCyc = settleProd[15:0];
  wire [15:0] penSettleCyc = settleProd[17:2]; // [R8]

  // First valid result in queue order
  reg [2:0] firstIdx;
  reg firstValid;
  integer k;
  always @* begin
    firstIdx = `CH_X;
    firstValid = 1'b0;
    for (k = `CHAN_COUNT - 1; k >= 0; k = k - 1) begin
      if (chanValidReg[k]) begin
        firstIdx = k[2:0]; // [R22]
        firstValid = 1'b1;
      end
    end
  end
  wire [15:0] popWord = firstValid ? {1'b0, firstIdx, chanData[firstIdx]} : `CHAN_EMPTY_WORD;

  // Bus decode
  wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [5:0] wbIdx = wb_adr_i[7:2];
  wire wbWr = wbReq & wb_we_i;
  wire wbRd = wbReq & ~wb_we_i;
  wire statusRead = wbRd & (wbIdx == `IDX_STATUS);
  wire wbPop = wbRd & (wbIdx == `IDX_CHAN_DATA);
  wire cmdStart = wbWr & (wbIdx == `IDX_COMMAND) & wb_sel_i[0] & wb_dat_i[`CMD_START_BIT];

  // Serial READCHAN pops on the eighth rising edge of the command byte
  wire spiPop = sclkRise & csActive & ~spiReadingReg & (spiBitCntReg == 4'h7) &
                (spiCmdReg[6:4] == `SPI_READCHAN) & ~busy; // [R21]
  wire popNow = wbPop | spiPop;

  wire touchSet = (stateReg == ST_PEN_EVAL) & pinLvl[`PIN_PEN]; // [R10]
  wire auxTrig = auxTrigEn & (ctrlReg[`CTRL_AUX_EDGE] ? auxRise : pinLvl[`PIN_AUX]); // [R12]

  // Channel enable: five-wire panels have no pressure or separate aux input
  reg [`CHAN_COUNT-1:0] chanEn;
  always @* begin
    chanEn = chanMaskReg;
    if (fiveWire) begin
      chanEn[`CH_Z1] = 1'b0; // [R18]
      chanEn[`CH_Z2] = 1'b0; // [R18]
      chanEn[`CH_AUX] = 1'b0; // [R13]
    end
    if (auxTrigEn) begin
      chanEn[`CH_AUX] = 1'b0;
    end
  end

  // Bias and ADC input per channel
  reg [2:0] chBias;
  reg [1:0] chAdcIn;
  always @* begin
    chBias = `BIAS_OFF;
    chAdcIn = `ADC_IN_XPLUS;
    case (chanIdxReg)
      `CH_X: begin
        chBias = `BIAS_X;
        chAdcIn = `ADC_IN_YSHEET; // [R15]
      end
      `CH_Y: begin
        chBias = `BIAS_Y;
        chAdcIn = `ADC_IN_XPLUS; // [R14]
      end
      `CH_Z1: begin
        chBias = `BIAS_Z1; // [R17]
        chAdcIn = `ADC_IN_XPLUS;
      end
      `CH_Z2: begin
        chBias = `BIAS_Z2; // [R17]
        chAdcIn = `ADC_IN_YSHEET;
      end
      `CH_AUX: begin
        chBias = `BIAS_AUX;
        chAdcIn = `ADC_IN_AUX; // [R11]
      end
      default: begin
        chBias = `BIAS_OFF;
        chAdcIn = `ADC_IN_XPLUS;
      end
    endcase
    if (fiveWire) begin
      chAdcIn = `ADC_IN_AUX; // [R13]
    end
  end

  // Wishbone slave: one wait state, every access acknowledged while the synchronised hardware reset pin level is high
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrlReg <= `CTRL_RESET;
      chanMaskReg <= `CHAN_MASK_RESET;
    end else if (ctlRst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrlReg <= `CTRL_RESET;
      chanMaskReg <= `CHAN_MASK_RESET;
    end else begin
      wb_ack_o <= wbReq;
      if (wbWr && wbIdx == `IDX_CTRL) begin
        if (wb_sel_i[0]) begin
          ctrlReg[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          ctrlReg[`CTRL_WIDTH-1:8] <= wb_dat_i[`CTRL_WIDTH-1:8];
        end
      end
      if (wbWr && wbIdx == `IDX_CHAN_MASK && wb_sel_i[0]) begin
        chanMaskReg <= wb_dat_i[`CHAN_COUNT-1:0];
      end
      if (wbRd) begin
        case (wbIdx)
          `IDX_CTRL: wb_dat_o <= {{(32-`CTRL_WIDTH){1'b0}}, ctrlReg};
          `IDX_CHAN_MASK: wb_dat_o <= {{(32-`CHAN_COUNT){1'b0}}, chanMaskReg};
          `IDX_STATUS: wb_dat_o <= {25'h0, stateReg, startPendReg, busy,
                                    |chanValidReg, touchFlagReg};
          `IDX_CHAN_DATA: wb_dat_o <= {16'h0, popWord}; // [R19]
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // Flags, sequencer and result queue
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      touchFlagReg <= 1'b0;
      startPendReg <= 1'b0;
      stateReg <= ST_IDLE;
      chanIdxReg <= `CH_X;
      waitCntReg <= 16'h0;
      chanValidReg <= {`CHAN_COUNT{1'b0}};
      adcStart <= 1'b0;
      biasSel <= `BIAS_OFF;
      adcInSel <= `ADC_IN_XPLUS;
      penPullupSel <= 2'h0;
    end else if (ctlRst) begin
      touchFlagReg <= 1'b0;
      startPendReg <= 1'b0;
      stateReg <= ST_IDLE;
      chanIdxReg <= `CH_X;
      waitCntReg <= 16'h0;
      chanValidReg <= {`CHAN_COUNT{1'b0}};
      adcStart <= 1'b0;
      biasSel <= `BIAS_OFF;
      adcInSel <= `ADC_IN_XPLUS;
      penPullupSel <= 2'h0;
    end else begin
      penPullupSel <= ctrlReg[`CTRL_PULLUP_HI:`CTRL_PULLUP_LO]; // [R9]
      touchFlagReg <= touchSet | (touchFlagReg & ~statusRead); // [R5] [R7]
      adcStart <= 1'b0;
      if ((cmdStart | auxTrig) && !busy) begin
        startPendReg <= 1'b1;
      end
      if (popNow && firstValid) begin
        chanValidReg[firstIdx] <= 1'b0; // [R22]
      end
      case (stateReg)
        ST_IDLE: begin
          biasSel <= `BIAS_OFF;
          if (startPendReg) begin
            startPendReg <= 1'b0;
            chanIdxReg <= `CH_X;
            stateReg <= ST_CH_SEL;
          end else if (penMode) begin
            biasSel <= `BIAS_PEN; // [R10]
            waitCntReg <= (penSettleCyc == 16'h0) ? 16'h1 : penSettleCyc;
            stateReg <= ST_PEN_BIAS;
          end
        end
        ST_PEN_BIAS: begin
          if (waitCntReg <= 16'h1) begin
            stateReg <= ST_PEN_EVAL; // [R8]
          end else begin
            waitCntReg <= waitCntReg - 16'h1;
          end
        end
        ST_PEN_EVAL: begin
          biasSel <= `BIAS_OFF;
          if (!pinLvl[`PIN_PEN]) begin
            stateReg <= ST_IDLE;
          end else if (mode == `MODE_PEN_TRIG) begin
            chanIdxReg <= `CH_X; // [R4]
            stateReg <= ST_CH_SEL;
          end else begin
            stateReg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!touchFlagReg || mode != `MODE_PEN_INT || startPendReg) begin
            stateReg <= ST_IDLE;
          end
        end
        ST_CH_SEL: begin
          if (chanIdxReg >= `CH_END) begin
            biasSel <= `BIAS_OFF;
            stateReg <= ST_IDLE;
          end else if (chanEn[chanIdxReg]) begin
            biasSel <= chBias;
            adcInSel <= chAdcIn;
            waitCntReg <= settleCyc;
            stateReg <= ST_SETTLE;
          end else begin
            chanIdxReg <= chanIdxReg + 3'h1;
          end
        end
        ST_SETTLE: begin
          if (waitCntReg <= 16'h1) begin
            adcStart <= 1'b1;
            stateReg <= ST_CONV;
          end else begin
            waitCntReg <= waitCntReg - 16'h1;
          end
        end
        ST_CONV: begin
          if (adcDone) begin
            chanData[chanIdxReg] <= adcData; // [R16] [R19]
            chanValidReg[chanIdxReg] <= 1'b1;
            chanIdxReg <= chanIdxReg + 3'h1;
            stateReg <= ST_CH_SEL;
          end
        end
        default: begin
          stateReg <= ST_IDLE;
        end
      endcase
    end
  end

  // Serial read-out: sample on rising, shift on falling, clock idles low
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      spiBitCntReg <= 4'h0;
      spiCmdReg <= 7'h0;
      spiOutReg <= 16'h0;
      spiReadingReg <= 1'b0;
      spiMisoOut <= 1'b0;
      spiMisoOe <= 1'b0;
    end else if (ctlRst || !csActive) begin
      spiBitCntReg <= 4'h0;
      spiCmdReg <= 7'h0;
      spiReadingReg <= 1'b0;
      spiMisoOut <= 1'b0;
      spiMisoOe <= 1'b0;
    end else begin
      spiMisoOe <= 1'b1;
      if (sclkRise && !spiReadingReg) begin
        spiCmdReg <= {spiCmdReg[5:0], pinLvl[`PIN_MOSI]}; // [R20]
        spiBitCntReg <= spiBitCntReg + 4'h1;
        if (spiPop) begin
          spiReadingReg <= 1'b1;
          spiOutReg <= popWord;
        end
      end
      if (sclkFall && spiReadingReg) begin
        spiMisoOut <= spiOutReg[15]; // [R20]
        spiOutReg <= {spiOutReg[14:0], 1'b0};
      end
    end
  end

  // Open-drain interrupt: output level fixed low, enable pulls the line
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hostInterruptNOut <= 1'b0;
      hostInterruptNOe <= 1'b0;
    end else begin
      hostInterruptNOut <= 1'b0; // [R1]
      hostInterruptNOe <= ~ctlRst & (((mode == `MODE_PEN_INT) & touchFlagReg &
                          ~statusRead) | (|chanValidReg)); // [R2] [R6] [R7]
    end
  end

endmodule

// ===== dv/touch_ctrl_checker.sv
/* Port checker for touch_ctrl.
   Assumes it is bound to touch_ctrl and sees only its ports. */
`timescale 1ns/1ps
`include "touch_ctrl_map.vh"
module touch_ctrl_checker (
  input wire ref_clk,
  input wire resetn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire hwResetNIn,
  input wire spiCsNIn,
  input wire spiMisoOe,
  input wire hostInterruptNOut,
  input wire hostInterruptNOe,
  input wire [2:0] biasSel,
  input wire [1:0] adcInSel,
  input wire [1:0] penPullupSel,
  input wire adcStart
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  reg [2:0] lastBias;
  reg [8:0] held;
  // Cycles since the bias setup last changed
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lastBias <= 3'h0;
      held <= 9'h000;
    end else begin
      lastBias <= biasSel;
      held <= (biasSel != lastBias) ? 9'h000 : (held == 9'h1ff ? held : held + 9'h001);
    end
  end
  sequence s_hwRun; hwResetNIn [*6]; endsequence
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  property p_ackAfterReq; s_hwRun ##0 s_req |=> wb_ack_o; endproperty
  a_ackAfterReq: assert property (p_ackAfterReq) else $error("request not acked");
  property p_irqDrive; hostInterruptNOe |-> !hostInterruptNOut; endproperty
  a_irqDrive: assert property (p_irqDrive) else $error("interrupt drives high");
  property p_hwReset; !hwResetNIn [*6] |-> !wb_ack_o && !hostInterruptNOe && !adcStart; endproperty
  a_hwReset: assert property (p_hwReset) else $error("activity in reset");
  property p_pullup;
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == `IDX_CTRL
      |=> penPullupSel == $past(wb_dat_i[4:3]);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up select wrong");
  property p_settle; adcStart |-> held >= 9'd195; endproperty
  a_settle: assert property (p_settle) else $error("conversion before settling");
  property p_xIn;
    adcStart && biasSel == `BIAS_X |-> adcInSel == `ADC_IN_YSHEET || adcInSel == `ADC_IN_AUX;
  endproperty
  a_xIn: assert property (p_xIn) else $error("X input wrong");
  property p_auxIn; adcStart && biasSel == `BIAS_AUX |-> adcInSel == `ADC_IN_AUX; endproperty
  a_auxIn: assert property (p_auxIn) else $error("aux input wrong");
  property p_noWiperZ;
    adcStart && (biasSel == `BIAS_Z1 || biasSel == `BIAS_Z2) |-> adcInSel != `ADC_IN_AUX;
  endproperty
  a_noWiperZ: assert property (p_noWiperZ) else $error("pressure on wiper");
  property p_misoOe; !spiCsNIn [*6] |-> spiMisoOe; endproperty
  a_misoOe: assert property (p_misoOe) else $error("serial out not enabled");
endmodule
bind touch_ctrl touch_ctrl_checker chk (.ref_clk(ref_clk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .hwResetNIn(hwResetNIn),
  .spiCsNIn(spiCsNIn), .spiMisoOe(spiMisoOe), .hostInterruptNOut(hostInterruptNOut),
  .hostInterruptNOe(hostInterruptNOe), .biasSel(biasSel), .adcInSel(adcInSel),
  .penPullupSel(penPullupSel), .adcStart(adcStart));

// ===== dv/spi_host_model.sv
/* Serial host issuing channel reads.
   Assumes the controller oversamples these pins; clock idles low. */
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk,
  output logic csN,
  output logic mosi,
  input wire logic miso,
  input wire logic misoOe
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b1;
  end
  task automatic readChan(output logic [15:0] w);
    logic [7:0] cmd;
    cmd = 8'h20;
    w = 16'h0;
    csN = 1'b0;
    #100;
    for (int i = 0; i < 24; i++) begin
      mosi = (i < 8) ? cmd[7 - i] : ~mosi;
      #62.5 sclk = 1'b1;
      if (i >= 8) w = {w[14:0], misoOe ? miso : 1'bx};
      #62.5 sclk = 1'b0;
    end
    #100 csN = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// ===== dv/tb_top.sv
/* Self-checking bench for touch_ctrl.
   Assumes the serial host model and a stand-in ADC answering each start. */
`timescale 1ns/1ps
`include "touch_ctrl_map.vh"
module tb_top;
  logic ref_clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] datI = 32'h0, datO, q;
  logic ack, hwRstN = 1'b1, pen = 1'b0, aux = 1'b0, sclk, csN, mosi, miso, misoOe;
  logic irqN, irqOe, adcStart, adcDone = 1'b0;
  logic [2:0] bias, curBias = 3'h0;
  logic [1:0] inSel, pull;
  logic [11:0] adcData = 12'h000;
  logic [2:0] bLog [0:31];
  logic [1:0] iLog [0:31];
  logic [15:0] w;
  int nStart = 0, dly = 0, nErrors = 0, checkCount = 0;
  wire irqLine = irqOe ? irqN : 1'b1;
  always #2.5 ref_clk = ~ref_clk;
  touch_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
    .wb_ack_o(ack), .hwResetNIn(hwRstN), .penDetectIn(pen), .auxPinIn(aux),
    .spiSclkIn(sclk), .spiCsNIn(csN), .spiMosiIn(mosi), .spiMisoOut(miso),
    .spiMisoOe(misoOe), .hostInterruptNOut(irqN), .hostInterruptNOe(irqOe),
    .biasSel(bias), .adcInSel(inSel), .penPullupSel(pull), .adcStart(adcStart),
    .adcDone(adcDone), .adcData(adcData));
  spi_host_model host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso), .misoOe(misoOe));
  // Stand-in ADC: result carries the bias setup it was taken under
  always @(posedge ref_clk) begin
    adcDone <= 1'b0;
    if (adcStart) begin
      bLog[nStart] <= bias;
      iLog[nStart] <= inSel;
      nStart <= nStart + 1;
      curBias <= bias;
      dly <= 4;
    end else if (dly > 0) begin
      dly <= dly - 1;
      if (dly == 1) begin
        adcDone <= 1'b1;
        adcData <= {4'ha, 5'h00, curBias};
      end
    end
  end
  function automatic logic [31:0] expWord(input logic [2:0] ch);
    return {16'h0, 1'b0, ch, 4'ha, 5'h00, ch + 3'h2};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    checkCount++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic wb(input logic wr, input logic [5:0] i, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {i, 2'b00};
    datI <= d;
    sel <= 4'hf;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (ack !== 1'b1 && k < 100);
    if (ack !== 1'b1) nErrors++;
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] i, input logic [31:0] e, input string s);
    wb(1'b0, i, 32'h0);
    chk(q, e, s);
  endtask
  task automatic waitStarts(input int n);
    for (int k = 0; k < 3000 && nStart < n; k++) @(posedge ref_clk);
    if (nStart < n) nErrors++;
  endtask
  task automatic waitIdle();
    int k;
    k = 0;
    do begin
      wb(1'b0, `IDX_STATUS, 32'h0);
      k++;
    end while (q[3:2] !== 2'b00 && k < 3000);
    if (q[3:2] !== 2'b00) nErrors++;
  endtask
  task automatic endSim();
    $display("errors %0d checks %0d", nErrors, checkCount);
    if (nErrors == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    nErrors++;
    endSim();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(`IDX_CTRL, 32'h0, "ctrl reset");
    rd(`IDX_CHAN_MASK, 32'h1f, "mask reset");
    rd(6'h0f, 32'h0, "unmapped");
    wb(1'b1, `IDX_COMMAND, 32'h1);
    waitStarts(1);
    wb(1'b1, `IDX_COMMAND, 32'h1);
    host.readChan(w);
    chk(w, 32'h0, "serial read busy");
    waitIdle();
    chk(nStart, 5, "conversions");
    for (int i = 0; i < 5; i++) chk(bLog[i], i + 2, "bias order");
    chk(iLog[0], `ADC_IN_YSHEET, "X input");
    chk(iLog[1], `ADC_IN_XPLUS, "Y input");
    chk(iLog[4], `ADC_IN_AUX, "aux input");
    chk(irqLine, 1'b0, "irq data");
    host.readChan(w);
    chk(w, expWord(3'h0), "serial X");
    for (int i = 1; i < 5; i++) rd(`IDX_CHAN_DATA, expWord(i), "queue word");
    rd(`IDX_CHAN_DATA, `CHAN_EMPTY_WORD, "queue empty");
    repeat (2) @(posedge ref_clk);
    chk(irqLine, 1'b1, "irq drained");
    for (int p = 0; p < 4; p++) begin
      wb(1'b1, `IDX_CTRL, 32'h1 | (p << 3));
      repeat (2) @(posedge ref_clk);
      chk(pull, p, "pull-up");
    end
    for (int k = 0; k < 10 && bias !== `BIAS_PEN; k++) @(posedge ref_clk);
    chk(bias, `BIAS_PEN, "pen bias");
    pen <= 1'b1;
    for (int k = 0; k < 1000 && irqLine !== 1'b0; k++) @(posedge ref_clk);
    chk(irqLine, 1'b0, "irq touch");
    chk(irqN, 1'b0, "irq level");
    chk(nStart, 5, "no run pen-int");
    pen <= 1'b0;
    repeat (20) @(posedge ref_clk);
    wb(1'b0, `IDX_STATUS, 32'h0);
    chk(q[0], 1'b1, "touch flag");
    repeat (2) @(posedge ref_clk);
    chk(irqLine, 1'b1, "irq released");
    wb(1'b0, `IDX_STATUS, 32'h0);
    chk(q[0], 1'b0, "flag cleared");
    wb(1'b1, `IDX_CHAN_MASK, 32'h1);
    wb(1'b1, `IDX_CTRL, 32'h2);
    pen <= 1'b1;
    waitStarts(6);
    pen <= 1'b0;
    waitIdle();
    rd(`IDX_CHAN_DATA, expWord(3'h0), "pen trigger");
    wb(1'b1, `IDX_CTRL, 32'h300);
    aux <= 1'b1;
    waitStarts(7);
    aux <= 1'b0;
    waitIdle();
    rd(`IDX_CHAN_DATA, expWord(3'h0), "aux trigger");
    wb(1'b1, `IDX_CHAN_MASK, 32'h1f);
    wb(1'b1, `IDX_CTRL, 32'h4);
    wb(1'b1, `IDX_COMMAND, 32'h1);
    waitStarts(8);
    waitIdle();
    chk(nStart, 9, "five-wire runs");
    chk(iLog[7], `ADC_IN_AUX, "wiper X");
    chk(iLog[8], `ADC_IN_AUX, "wiper Y");
    rd(`IDX_CHAN_DATA, expWord(3'h0), "five-wire X");
    rd(`IDX_CHAN_DATA, expWord(3'h1), "five-wire Y");
    rd(`IDX_CHAN_DATA, `CHAN_EMPTY_WORD, "five-wire end");
    wb(1'b1, `IDX_CTRL, 32'h1c);
    hwRstN <= 1'b0;
    repeat (10) @(posedge ref_clk);
    hwRstN <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(`IDX_CTRL, 32'h0, "ctrl after pin reset");
    endSim();
  end
endmodule
